// ---- design/charger_regs_pkg.sv ----
/*
 * Shared definitions for the termination/boost register bank: offsets,
 * field positions, reset values, fault codes and timing constants.
 * Assumes a 40 MHz core clock.
 */
package charger_regs_pkg;

    // Register offsets on the serial control interface
    localparam logic [7:0] term_recharge_config_addr = 8'h07;
    localparam logic [7:0] maker_identifier_addr = 8'h08;
    localparam logic [7:0] boost_fault_status_addr = 8'h09;
    localparam logic [7:0] boost_driver_config_addr = 8'h0a;

    // Reset values
    localparam logic [7:0] term_recharge_config_rst = 8'h11;
    localparam logic [7:0] boost_fault_status_rst = 8'h00;
    localparam logic [7:0] boost_driver_config_rst = 8'h00;

    // Writable bit masks; unused bits stay zero
    localparam logic [7:0] term_recharge_config_mask = 8'hfb;
    localparam logic [7:0] boost_driver_config_mask = 8'hfb;

    // Field positions, termination/recharge register
    localparam int term_window_len_pos = 7;
    localparam int term_hit_count_pos = 5;
    localparam int term_deglitch_pos = 3;
    localparam int recharge_offset_pos = 0;

    // Field positions, boost driver register
    localparam int switch_freq_shift_pos = 7;
    localparam int driver_slew_pos = 5;
    localparam int fixed_deadtime_pos = 4;
    localparam int forced_modulation_pos = 3;
    localparam int otg_voltage_pos = 0;

    // Boost fault codes
    localparam logic [2:0] fault_normal = 3'h0;
    localparam logic [2:0] fault_input_ovp = 3'h1;
    localparam logic [2:0] fault_overload = 3'h2;
    localparam logic [2:0] fault_batt_low = 3'h3;
    localparam logic [2:0] fault_thermal = 3'h5;

    // Termination timing
    localparam longint clk_hz = 40000000;
    localparam longint deglitch_base_ms = 8;
    localparam longint deglitch_base_cycles = (deglitch_base_ms * clk_hz) / 1000;
    localparam int window_short_periods = 8;
    localparam int window_long_periods = 16;

    // Bus request and fault status samples
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [2:0] code;
        logic valid;
    } fault_in_s;

endpackage

// ---- design/term_counter.sv ----
/*
 * Termination qualifier: counts deglitched periods with charge current
 * below threshold inside a window of periods.
 * Assumes below_term is already synchronised to clk.
 */
module term_counter #(
    parameter longint base_cycles = charger_regs_pkg::deglitch_base_cycles
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic enable,
    input wire logic window_long,
    input wire logic [1:0] hit_sel,
    input wire logic [1:0] deglitch_sel,
    input wire logic below_term,
    // Result
    output logic done
);

    typedef struct packed {
        logic [31:0] timer;
        logic [4:0] period;
        logic [3:0] hits;
        logic period_ok;
        logic done;
    } cnt_state_s;

    cnt_state_s state;
    cnt_state_s next_state;
    logic [31:0] period_len;
    logic [4:0] window_len;
    logic [3:0] hit_need;

    always_comb begin
        period_len = 32'(base_cycles << deglitch_sel);
        window_len = window_long ? 5'(charger_regs_pkg::window_short_periods * 2)
                                 : 5'(charger_regs_pkg::window_short_periods);
        hit_need = 4'(1) << hit_sel;
        next_state = state;
        if (!enable) begin
            // Period qualifier armed, so the first period after enable can count
            next_state = '0;
            next_state.period_ok = 1'b1;
        end else if (!state.done) begin
            next_state.period_ok = state.period_ok & below_term;
            if (state.timer >= period_len - 32'd1) begin
                next_state.timer = '0;
                next_state.period_ok = 1'b1;
                if (state.period_ok && below_term) begin
                    next_state.hits = state.hits + 4'd1;
                    if (state.hits + 4'd1 >= hit_need) begin
                        next_state.done = 1'b1;
                    end
                end
                if (state.period + 5'd1 >= window_len && !next_state.done) begin
                    next_state.period = '0;
                    next_state.hits = '0;
                end else begin
                    next_state.period = state.period + 5'd1;
                end
            end else begin
                next_state.timer = state.timer + 32'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '{timer: '0, period: '0, hits: '0, period_ok: 1'b1, done: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign done = state.done;

    a_done_needs_enable: assert property (@(posedge clk) disable iff (rst)
        !enable |=> !done) else $error("termination flagged while disabled");
    a_hits_bounded: assert property (@(posedge clk) disable iff (rst)
        state.hits <= 4'd8) else $error("hit counter overflow");
    a_window_bound: assert property (@(posedge clk) disable iff (rst)
        state.period <= 5'd16) else $error("window counter overflow");

endmodule // term_counter

// ---- design/charger_term_boost_regs.sv ----
/*
 * Register bank for charge termination, recharge offset, boost fault
 * reporting and buck/boost driver options, with termination qualifier.
 * Assumes the serial interface decoder delivers single-cycle read/write
 * strobes on clk, and fault/current-sense inputs come from analog pins.
 */
// Summary of operation
// - Window length bit selects 8 periods when clear, 16 when set.
// - Hit count field needs 1, 2, 4 or 8 low-current periods.
// - Deglitch field gives 8, 16, 32 or 64 ms per period.
// - Recharge offset field gives 50, 100, 150 or 200 mV below regulation.
// - Termination/recharge register resets to 0x11.
// - Read-only boost fault field reports normal, OVP, overload, low battery, thermal.
// - Frequency shift bit picks 1.5 MHz clear, 1.7 MHz set.
// - Driver slew field picks default, slow, slower, slowest driver.
// - Dead-time bit picks multi-stage driver clear, fixed dead-time set.
// - Forced modulation bit forces continuous PWM in boost mode.
// - Boost output field picks 5.05, 5.15, 5.25 or 5.35 V.
module charger_term_boost_regs #(
    parameter logic [7:0] maker_id = 8'h5a, // Arbitrary value
    parameter longint deglitch_cycles = charger_regs_pkg::deglitch_base_cycles
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access from the serial interface
    input wire charger_regs_pkg::reg_req_s req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Analog status in
    input wire charger_regs_pkg::fault_in_s fault_in,
    input wire logic below_term_pin,
    input wire logic term_enable,
    // Configuration out
    output logic term_done,
    output logic [1:0] recharge_offset,
    output logic switch_freq_shift,
    output logic [1:0] driver_slew_sel,
    output logic fixed_deadtime_sel,
    output logic forced_modulation,
    output logic [1:0] otg_output_voltage
);

    typedef struct packed {
        logic [7:0] term_cfg;
        logic [7:0] drv_cfg;
        logic [2:0] fault;
        logic [2:0] below_sync;
        logic below;
        logic [7:0] rdata;
        logic rvalid;
        logic term_done;
    } bank_state_s;

    bank_state_s state;
    bank_state_s next_state;
    logic cnt_done;

    // Decode shared by read mux
    function automatic logic [7:0] read_reg(input logic [7:0] addr, input bank_state_s s);
        case (addr)
            charger_regs_pkg::term_recharge_config_addr: read_reg = s.term_cfg;
            charger_regs_pkg::maker_identifier_addr: read_reg = maker_id;
            charger_regs_pkg::boost_fault_status_addr: read_reg = {5'h00, s.fault};
            charger_regs_pkg::boost_driver_config_addr: read_reg = s.drv_cfg;
            default: read_reg = 8'h00;
        endcase
    endfunction

    function automatic logic [2:0] fault_filter(input logic [2:0] code);
        case (code)
            charger_regs_pkg::fault_input_ovp,
            charger_regs_pkg::fault_overload,
            charger_regs_pkg::fault_batt_low,
            charger_regs_pkg::fault_thermal: fault_filter = code;
            default: fault_filter = charger_regs_pkg::fault_normal;
        endcase
    endfunction

    always_comb begin
        next_state = state;
        // Three-stage synchroniser; change taken when stages two and three agree
        next_state.below_sync = {state.below_sync[1:0], below_term_pin};
        if (state.below_sync[2] == state.below_sync[1]) begin
            next_state.below = state.below_sync[2];
        end
        // Fault source is analog status already qualified by its valid
        if (fault_in.valid) begin
            next_state.fault = fault_filter(fault_in.code);
        end
        if (req.wr) begin
            if (req.addr == charger_regs_pkg::term_recharge_config_addr) begin
                next_state.term_cfg = req.wdata & charger_regs_pkg::term_recharge_config_mask;
            end
            if (req.addr == charger_regs_pkg::boost_driver_config_addr) begin
                next_state.drv_cfg = req.wdata & charger_regs_pkg::boost_driver_config_mask;
            end
        end
        next_state.rvalid = req.rd;
        if (req.rd) begin
            next_state.rdata = read_reg(req.addr, state);
        end
        next_state.term_done = cnt_done;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
            state.term_cfg <= charger_regs_pkg::term_recharge_config_rst;
            state.drv_cfg <= charger_regs_pkg::boost_driver_config_rst;
            state.fault <= charger_regs_pkg::boost_fault_status_rst[2:0];
        end else begin
            state <= next_state;
        end
    end

    term_counter #(
        .base_cycles(deglitch_cycles)
    ) u_term_counter (
        .clk(clk),
        .rst(rst),
        .enable(term_enable),
        .window_long(state.term_cfg[charger_regs_pkg::term_window_len_pos]),
        .hit_sel(state.term_cfg[charger_regs_pkg::term_hit_count_pos +: 2]),
        .deglitch_sel(state.term_cfg[charger_regs_pkg::term_deglitch_pos +: 2]),
        .below_term(state.below),
        .done(cnt_done)
    );

    assign rdata = state.rdata;
    assign rvalid = state.rvalid;
    assign term_done = state.term_done;
    assign recharge_offset = state.term_cfg[charger_regs_pkg::recharge_offset_pos +: 2];
    assign switch_freq_shift = state.drv_cfg[charger_regs_pkg::switch_freq_shift_pos];
    assign driver_slew_sel = state.drv_cfg[charger_regs_pkg::driver_slew_pos +: 2];
    assign fixed_deadtime_sel = state.drv_cfg[charger_regs_pkg::fixed_deadtime_pos];
    assign forced_modulation = state.drv_cfg[charger_regs_pkg::forced_modulation_pos];
    assign otg_output_voltage = state.drv_cfg[charger_regs_pkg::otg_voltage_pos +: 2];

    sequence s_write_term(logic [7:0] d);
        req.wr && req.addr == charger_regs_pkg::term_recharge_config_addr && req.wdata == d;
    endsequence

    a_reset_value: assert property (@(posedge clk)
        rst |=> state.term_cfg == 8'h11) else $error("term config reset value wrong");
    a_unused_zero: assert property (@(posedge clk) disable iff (rst)
        state.term_cfg[2] == 1'b0 && state.drv_cfg[2] == 1'b0) else $error("unused bit set");
    a_fault_legal: assert property (@(posedge clk) disable iff (rst)
        state.fault != 3'h4 && state.fault[2:1] != 2'b11) else $error("illegal fault code");
    a_read_fault: assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == 8'h09 |=> rvalid && rdata == {5'h00, $past(state.fault)})
        else $error("fault read mismatch");
    a_write_recharge: assert property (@(posedge clk) disable iff (rst)
        s_write_term(8'h0b) |=> recharge_offset == 2'h3 && term_done == $past(cnt_done))
        else $error("recharge offset not written");
    a_drv_write: assert property (@(posedge clk) disable iff (rst)
        req.wr && req.addr == 8'h0a |=> {switch_freq_shift, driver_slew_sel, fixed_deadtime_sel,
        forced_modulation, otg_output_voltage} == {$past(req.wdata[7:3]), $past(req.wdata[1:0])})
        else $error("driver config not written");
    a_window_bit: assert property (@(posedge clk) disable iff (rst)
        s_write_term(8'he0) |=> state.term_cfg[7] && state.term_cfg[6:5] == 2'h3 && state.term_cfg[4:3] == 2'h0)
        else $error("window bit not written");
    a_no_done_disabled: assert property (@(posedge clk) disable iff (rst)
        !term_enable ##1 !term_enable |=> !term_done) else $error("done without enable");

endmodule // charger_term_boost_regs

// ---- dv/host_model.sv ----
/*
 * Host-side model of the serial control interface decoder: issues single
 * write and read strobes to the register bank.
 * Assumes the bench owns clk and calls the tasks from one process only.
 */
module host_model (
    // Clock
    input wire logic clk,
    // Request out, answer in
    output charger_regs_pkg::reg_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic timed_out;
    initial begin
        req = '0;
        timed_out = 1'b0;
    end
    // Idle address and data are inverted so stale values cannot pass
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
        timed_out = (rvalid !== 1'b1);
        d = rdata;
    endtask
endmodule // host_model

// ---- dv/tb_charger_term_boost_regs.sv ----
/*
 * Self-checking bench for the termination/boost register bank.
 * Assumes a shortened deglitch period of 4 cycles per base step.
 */
`define CHK(name, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("BAD %s expected %h seen %h", name, exp, got); \
        end \
    end
module tb_charger_term_boost_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] id_val = 8'h3c; // Arbitrary value
    logic clk, rst, rvalid, below, ten, term_done, fsw, fdt, fmod;
    logic [7:0] rdata;
    logic [1:0] rch, slew, otg;
    charger_regs_pkg::reg_req_s req;
    charger_regs_pkg::fault_in_s fault_in;
    int fail_count, samples_checked;
    host_model u_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    charger_term_boost_regs #(.maker_id(id_val), .deglitch_cycles(4)) u_charger_term_boost_regs (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .fault_in(fault_in),
        .below_term_pin(below), .term_enable(ten), .term_done(term_done), .recharge_offset(rch),
        .switch_freq_shift(fsw), .driver_slew_sel(slew), .fixed_deadtime_sel(fdt),
        .forced_modulation(fmod), .otg_output_voltage(otg));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        u_host_model.rd_reg(a, d);
        if (u_host_model.timed_out) begin
            fail_count++;
            finish_test();
        end else begin
            `CHK(name, exp, d)
        end
    endtask
    task automatic t_reset();
        `CHK("rch", 2'h1, rch)
        `CHK("drv", 8'h00, {fsw, slew, fdt, fmod, otg, term_done})
        rd_chk(8'h07, 8'h11, "term cfg");
        rd_chk(8'h08, id_val, "maker id");
        rd_chk(8'h09, 8'h00, "fault");
        rd_chk(8'h0a, 8'h00, "drv cfg");
        rd_chk(8'h0b, 8'h00, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_mask();
        u_host_model.wr_reg(8'h07, 8'hff);
        rd_chk(8'h07, 8'hfb, "term mask");
        u_host_model.wr_reg(8'h08, 8'h00);
        u_host_model.wr_reg(8'h09, 8'h07);
        rd_chk(8'h08, id_val, "id ro");
        rd_chk(8'h09, 8'h00, "fault ro");
        u_host_model.wr_reg(8'h0a, 8'hff);
        rd_chk(8'h0a, 8'hfb, "drv mask");
        `CHK("fsw", 1'b1, fsw)
        `CHK("fdt", 1'b1, fdt)
        `CHK("fmod", 1'b1, fmod)
        u_host_model.wr_reg(8'h0a, 8'h00);
        rd_chk(8'h0a, 8'h00, "drv clr");
        `CHK("bits", 3'h0, {fsw, fdt, fmod})
        $display("test mask done");
    endtask
    task automatic t_fields();
        for (int i = 0; i < 4; i++) begin
            u_host_model.wr_reg(8'h0a, {1'b0, 2'(i), 3'h0, 2'(i)});
            u_host_model.wr_reg(8'h07, {6'h02, 2'(i)});
            `CHK("slew", 2'(i), slew)
            `CHK("otg", 2'(i), otg)
            `CHK("rch", 2'(i), rch)
            rd_chk(8'h07, {6'h02, 2'(i)}, "term rb");
        end
        $display("test fields done");
    endtask
    task automatic t_fault();
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            fault_in <= '{code: 3'(c), valid: 1'b1};
            @(negedge clk);
            fault_in <= '{code: ~3'(c), valid: 1'b0};
            rd_chk(8'h09, (c == 4 || c >= 6) ? 8'h00 : 8'(c), "fault code");
        end
        $display("test fault done");
    endtask
    // Done must not show within lo cycles, and must show (or not) by hi
    task automatic term_run(input logic [7:0] cfg, input logic b, input logic exp, input int lo, input int hi);
        int n;
        u_host_model.wr_reg(8'h07, cfg);
        ten <= 1'b0;
        below <= b;
        repeat (8) @(negedge clk);
        ten <= 1'b1;
        for (n = 0; n < hi && term_done !== 1'b1; n++) @(negedge clk);
        `CHK("term done", exp, term_done)
        `CHK("term early", 1'b1, n > lo)
        ten <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("term clear", 1'b0, term_done)
    endtask
    task automatic t_term();
        term_run(8'h00, 1'b1, 1'b1, 2, 30);
        term_run(8'h00, 1'b0, 1'b0, 2, 60);
        term_run(8'h60, 1'b1, 1'b1, 24, 60);
        term_run(8'h18, 1'b1, 1'b1, 24, 60);
        term_run(8'he0, 1'b1, 1'b1, 24, 60);
        $display("test term done");
    endtask
    initial begin
        rst = 1'b1;
        below = 1'b0;
        ten = 1'b0;
        fault_in = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (4) @(negedge clk);
        rst <= 1'b0;
        t_reset();
        t_mask();
        t_fields();
        t_fault();
        t_term();
        finish_test();
    end
endmodule // tb_charger_term_boost_regs
